// ### rtl/pac_port.sv
// Conversion control and parallel host port of the eight-channel converter.
// Summary of operation
// - Busy rises after the trigger falls and stays high through the conversion.
// - Busy falls on the same edge that the new result is pushed into the result buffer.
// - Sampling returns to track on the 13th master-clock rising edge.
// - A conversion lasts thirteen master-clock cycles plus a fixed extra delay.
// - A trigger falling edge switches track to hold and starts conversion.
// - In automatic power-down modes a trigger rising edge powers the device up.
// - Write strobe with chip select low captures bus data into the register.
// - Read strobe falling with chip select low drives the result onto the bus.
// - Upper data pins carry result bits and word-mode write data, gated by strobes.
// - Word/byte select high gives full words; low gives bytes with bit 8 as byte enable.
// - Byte-mode high byte reads carry channel id on bits 4-6; writes need bits 4-7 zero.
`timescale 1ns/1ns
module pac_port #(
   parameter int T2_CYC = pac_pkg::T2_CYCLES
) (
   // Clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_n_i,
   // Host control pins
   input  wire logic                       sample_trigger_n_i,
   input  wire logic                       cs_n_i,
   input  wire logic                       rd_n_i,
   input  wire logic                       wr_n_i,
   input  wire logic                       word_mode_i,
   input  wire logic                       master_clock_input_i,
   output logic                            busy_o,
   // Data bus
   input  wire logic [pac_pkg::DATA_W-1:0] db_i,
   output logic [pac_pkg::DATA_W-1:0]      db_o,
   output logic [pac_pkg::DATA_W-1:0]      db_oe_o,
   // Converter core
   input  wire logic [pac_pkg::DATA_W-1:0] conv_code_i,
   output logic                            hold_o,
   output logic [pac_pkg::CHAN_W-1:0]      chan_sel_o,
   output logic                            powered_o
);

   pac_pkg::pac_pins_t  pins_in;
   pac_pkg::pac_pins_t  sync1_q;
   pac_pkg::pac_pins_t  sync2_q;
   pac_pkg::pac_pins_t  sync3_q;
   pac_pkg::pac_pins_t  filt_q;
   pac_pkg::pac_pins_t  filt_d;
   pac_pkg::pac_state_t state_q;
   pac_pkg::pac_result_t buf_in;
   pac_pkg::pac_result_t buf_out;

   logic [pac_pkg::EDGE_CNT_W-1:0] edge_cnt_q;
   logic [pac_pkg::DLY_CNT_W-1:0]  dly_cnt_q;
   logic [pac_pkg::DATA_W-1:0]     ctrl_q;
   logic [7:0]                     low_stage_q;
   logic [pac_pkg::CHAN_W-1:0]     conv_chan_q;
   logic [pac_pkg::CTRL_PM_W-1:0]  pm;
   logic                           trig_fall;
   logic                           trig_rise;
   logic                           mclk_rise;
   logic                           rd_fall;
   logic                           rd_rise;
   logic                           wr_rise;
   logic                           selected;
   logic                           reading;
   logic                           high_byte_enable;
   logic                           buf_in_valid;
   logic                           buf_in_ready;
   logic                           buf_out_valid;
   logic                           buf_pop;

   assign pins_in = '{trig_n: sample_trigger_n_i, cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
                      word_mode: word_mode_i, mclk: master_clock_input_i, db: db_i};

   // Three-stage sampling of all host pins; the first stage feeds only the second.
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= pac_pkg::PINS_RESET;
         sync2_q <= pac_pkg::PINS_RESET;
         sync3_q <= pac_pkg::PINS_RESET;
         filt_q  <= pac_pkg::PINS_RESET;
      end else begin
         sync1_q <= pins_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         filt_q  <= filt_d;
      end
   end

   // A pin level is accepted only once the second and third stages agree.
   genvar g;
   generate
      for (g = 0; g < $bits(pac_pkg::pac_pins_t); g++) begin : g_filt
         assign filt_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : filt_q[g];
      end
   endgenerate

   assign trig_fall = filt_q.trig_n & ~filt_d.trig_n;
   assign trig_rise = ~filt_q.trig_n & filt_d.trig_n;
   assign mclk_rise = ~filt_q.mclk & filt_d.mclk;
   assign rd_fall   = filt_q.rd_n & ~filt_d.rd_n;
   assign rd_rise   = ~filt_q.rd_n & filt_d.rd_n;
   assign wr_rise   = ~filt_q.wr_n & filt_d.wr_n;
   assign selected  = ~filt_d.cs_n;
   assign reading   = selected & ~filt_d.rd_n;
   assign high_byte_enable      = filt_d.db[pac_pkg::HIGH_BYTE_ENABLE_BIT];
   assign pm        = ctrl_q[pac_pkg::CTRL_PM_LSB +: pac_pkg::CTRL_PM_W];

   // Conversion sequencer.
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= pac_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            pac_pkg::ST_IDLE: begin
               if (pm == pac_pkg::PM_FULL_DOWN) begin
                  state_q <= pac_pkg::ST_DOWN;
               end else if (trig_fall) begin
                  state_q <= pac_pkg::ST_CONV;
               end
            end
            pac_pkg::ST_CONV: begin
               // Only master-clock edges advance, so gaps in a burst clock just stretch the wait.
               if (mclk_rise && edge_cnt_q == pac_pkg::EDGE_CNT_W'(pac_pkg::CONV_EDGES - 1)) begin
                  state_q <= pac_pkg::ST_SETTLE;
               end
            end
            pac_pkg::ST_SETTLE: begin
               if (dly_cnt_q == pac_pkg::DLY_CNT_W'(T2_CYC - 1)) begin
                  state_q <= pac_pkg::ST_LOAD;
               end
            end
            pac_pkg::ST_LOAD: begin
               if (buf_in_ready) begin
                  if (pm == pac_pkg::PM_AUTO_DOWN || pm == pac_pkg::PM_AUTO_STBY ||
                      pm == pac_pkg::PM_FULL_DOWN) begin
                     state_q <= pac_pkg::ST_DOWN;
                  end else begin
                     state_q <= pac_pkg::ST_IDLE;
                  end
               end
            end
            pac_pkg::ST_DOWN: begin
               if (pm == pac_pkg::PM_NORMAL) begin
                  state_q <= pac_pkg::ST_IDLE;
               end else if (trig_rise && pm != pac_pkg::PM_FULL_DOWN) begin
                  state_q <= pac_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= pac_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Master-clock edge counter and extra-delay counter.
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edge_cnt_q <= '0;
         dly_cnt_q  <= '0;
      end else begin
         if (state_q != pac_pkg::ST_CONV) begin
            edge_cnt_q <= '0;
         end else if (mclk_rise) begin
            edge_cnt_q <= edge_cnt_q + 1'b1;
         end
         if (state_q != pac_pkg::ST_SETTLE) begin
            dly_cnt_q <= '0;
         end else begin
            dly_cnt_q <= dly_cnt_q + 1'b1;
         end
      end
   end

   // Busy, track/hold, power and channel outputs.
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o      <= 1'b0;
         hold_o      <= 1'b0;
         powered_o   <= 1'b1;
         conv_chan_q <= '0;
      end else begin
         if (state_q == pac_pkg::ST_IDLE && pm != pac_pkg::PM_FULL_DOWN && trig_fall) begin
            busy_o      <= 1'b1;
            hold_o      <= 1'b1;
            conv_chan_q <= ctrl_q[pac_pkg::CTRL_CHAN_LSB +: pac_pkg::CHAN_W];
         end
         if (state_q == pac_pkg::ST_CONV && mclk_rise &&
             edge_cnt_q == pac_pkg::EDGE_CNT_W'(pac_pkg::CONV_EDGES - 1)) begin
            hold_o <= 1'b0;
         end
         // A full buffer holds busy high, so the host never loses an unread result.
         if (state_q == pac_pkg::ST_LOAD && buf_in_ready) begin
            busy_o <= 1'b0;
         end
         powered_o <= (state_q != pac_pkg::ST_DOWN);
      end
   end

   assign chan_sel_o   = conv_chan_q;
   assign buf_in_valid = (state_q == pac_pkg::ST_LOAD);
   assign buf_in       = '{chan: conv_chan_q, code: conv_code_i};

   // A word read, or the high byte of a byte pair, releases the entry.
   assign buf_pop = rd_rise & selected & (filt_q.word_mode | high_byte_enable);

   pac_result_buf #(
      .WIDTH ($bits(pac_pkg::pac_result_t)),
      .DEPTH (pac_pkg::BUF_DEPTH)
   ) u_buf (
      .sys_clk_i   (sys_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (buf_in_valid),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (buf_in),
      .out_valid_o (buf_out_valid),
      .out_ready_i (buf_pop),
      .out_data_o  (buf_out)
   );

   // Register writes on the write strobe's rising edge.
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q      <= pac_pkg::CTRL_RESET;
         low_stage_q <= pac_pkg::LOW_STAGE_RESET;
      end else if (wr_rise && selected) begin
         if (filt_d.word_mode) begin
            ctrl_q <= filt_d.db;
         end else if (!high_byte_enable) begin
            low_stage_q <= filt_d.db[7:0];
         end else if (filt_d.db[7:4] == 4'h0) begin
            ctrl_q <= {filt_d.db[3:0], low_stage_q};
         end
      end
   end

   // Bus drivers; enables stay on only while chip select and read are both low.
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         db_o    <= '0;
         db_oe_o <= '0;
      end else begin
         if (!reading) begin
            db_oe_o <= '0;
         end else if (rd_fall || db_oe_o != '0) begin
            db_oe_o <= filt_d.word_mode ? pac_pkg::OE_WORD : pac_pkg::OE_BYTE;
         end
         if (!buf_out_valid) begin
            db_o <= '0;
         end else if (filt_d.word_mode) begin
            db_o <= buf_out.code;
         end else if (high_byte_enable) begin
            db_o <= {4'h0, 1'b0, buf_out.chan, buf_out.code[11:8]};
         end else begin
            db_o <= {4'h0, buf_out.code[7:0]};
         end
      end
   end

endmodule

// ### rtl/pac_pkg.sv
// Shared constants and types for the parallel converter port.
package pac_pkg;

   // Data path widths and result buffer depth.
   localparam int DATA_W      = 12;
   localparam int CHAN_W      = 3;
   localparam int BUF_DEPTH   = 2;

   // Conversion timing.
   localparam int CLK_PERIOD_NS   = 10;
   localparam int CONV_EDGES      = 13;
   localparam int EDGE_CNT_W      = 4;
   localparam int T2_NS           = 20;
   localparam int T2_CYCLES_RAW   = (T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T2_CYCLES       = (T2_CYCLES_RAW < 1) ? 1 : T2_CYCLES_RAW;
   localparam int DLY_CNT_W       = 8;

   // Control register layout and value after reset.
   localparam int CTRL_PM_LSB   = 0;
   localparam int CTRL_PM_W     = 2;
   localparam int CTRL_CHAN_LSB = 6;
   localparam logic [DATA_W-1:0] CTRL_RESET = 12'h000;
   localparam logic [7:0]        LOW_STAGE_RESET = 8'h00;

   // Power management codes held in the control register.
   localparam logic [CTRL_PM_W-1:0] PM_NORMAL    = 2'h0;
   localparam logic [CTRL_PM_W-1:0] PM_AUTO_DOWN = 2'h1;
   localparam logic [CTRL_PM_W-1:0] PM_AUTO_STBY = 2'h2;
   localparam logic [CTRL_PM_W-1:0] PM_FULL_DOWN = 2'h3;

   // Byte lane masks for the data bus drivers.
   localparam logic [DATA_W-1:0] OE_WORD = 12'hfff;
   localparam logic [DATA_W-1:0] OE_BYTE = 12'h0ff;
   localparam int HIGH_BYTE_ENABLE_BIT = 8;

   // Host pins, sampled together.
   typedef struct packed {
      logic              trig_n;
      logic              cs_n;
      logic              rd_n;
      logic              wr_n;
      logic              word_mode;
      logic              mclk;
      logic [DATA_W-1:0] db;
   } pac_pins_t;

   localparam pac_pins_t PINS_RESET = '{trig_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                         word_mode: 1'b1, mclk: 1'b0, db: 12'h000};

   // One converted result with the channel it came from.
   typedef struct packed {
      logic [CHAN_W-1:0] chan;
      logic [DATA_W-1:0] code;
   } pac_result_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CONV,
      ST_SETTLE,
      ST_LOAD,
      ST_DOWN
   } pac_state_t;

endpackage

// ### rtl/pac_result_buf.sv
// Two-entry result buffer with valid and ready on both sides.
`timescale 1ns/1ns
module pac_result_buf #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [PTR_W:0]   count_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count_q != (PTR_W+1)'(DEPTH));
   assign out_valid_o = (count_q != '0);
   assign out_data_o  = mem_q[rd_ptr_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule

// ### bench/pac_port_chk.sv
// Pin timing checker for the converter port, bound to its top module.
`timescale 1ns/1ns
module pac_port_chk #(
   parameter int T2_CYC = pac_pkg::T2_CYCLES
) (
   // Clock and reset
   input wire logic                       sys_clk_i,
   input wire logic                       rst_n_i,
   // Host control pins
   input wire logic                       sample_trigger_n_i,
   input wire logic                       cs_n_i,
   input wire logic                       rd_n_i,
   input wire logic                       wr_n_i,
   input wire logic                       word_mode_i,
   input wire logic                       master_clock_input_i,
   input wire logic                       busy_o,
   // Data bus
   input wire logic [pac_pkg::DATA_W-1:0] db_i,
   input wire logic [pac_pkg::DATA_W-1:0] db_o,
   input wire logic [pac_pkg::DATA_W-1:0] db_oe_o,
   // Converter core
   input wire logic [pac_pkg::DATA_W-1:0] conv_code_i,
   input wire logic                       hold_o,
   input wire logic [pac_pkg::CHAN_W-1:0] chan_sel_o,
   input wire logic                       powered_o
);
   logic [4:0] edges_q;

   // Master-clock rises seen while holding; both pins pass the same sampler, so the lag cancels.
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edges_q <= 5'h00;
      end else if (!hold_o) begin
         edges_q <= 5'h00;
      end else if ($rose(master_clock_input_i)) begin
         edges_q <= edges_q + 5'h01;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_busy_start: assert property ($fell(sample_trigger_n_i) && !busy_o && powered_o |-> ##[2:6] busy_o && hold_o)
      else $error("busy or hold did not rise after trigger fall");
   a_hold_in_busy: assert property (hold_o |-> busy_o)
      else $error("hold without busy");
   a_hold_count: assert property ($fell(hold_o) |-> edges_q == 5'h0d)
      else $error("track resumed on wrong master clock edge");
   a_busy_after_hold: assert property ($fell(hold_o) |-> busy_o[*3])
      else $error("busy fell too soon after track");
   a_oe_idle: assert property (cs_n_i[*6] |-> db_oe_o == 12'h000)
      else $error("bus driven without chip select");
   a_oe_word: assert property ($fell(rd_n_i) && !cs_n_i && word_mode_i |-> ##[2:6] db_oe_o == pac_pkg::OE_WORD)
      else $error("word read not driven");
   a_oe_byte: assert property ($fell(rd_n_i) && !cs_n_i && !word_mode_i |-> ##[2:6] db_oe_o == pac_pkg::OE_BYTE)
      else $error("byte read lanes wrong");
   a_rd_off: assert property ($rose(rd_n_i) |-> ##[2:6] db_oe_o == 12'h000)
      else $error("bus still driven after read");
   a_wake_rise: assert property ($rose(sample_trigger_n_i) && !powered_o |-> ##[2:6] powered_o)
      else $error("trigger rise did not power up");
endmodule

bind pac_port pac_port_chk #(.T2_CYC(T2_CYC)) u_pac_port_chk (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sample_trigger_n_i(sample_trigger_n_i),
   .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .word_mode_i(word_mode_i),
   .master_clock_input_i(master_clock_input_i), .busy_o(busy_o), .db_i(db_i), .db_o(db_o),
   .db_oe_o(db_oe_o), .conv_code_i(conv_code_i), .hold_o(hold_o), .chan_sel_o(chan_sel_o),
   .powered_o(powered_o));

// ### bench/pac_host_model.sv
// Host processor model that drives the converter's pins and master clock.
`timescale 1ns/1ns
module pac_host_model (
   // Clock
   input  wire logic                       sys_clk_i,
   // Converter outputs
   input  wire logic                       busy_i,
   input  wire logic                       hold_i,
   input  wire logic [pac_pkg::DATA_W-1:0] bus_i,
   // Host pins
   output pac_pkg::pac_pins_t              pins_o
);
   logic       mclk_run;
   logic [1:0] phase;

   initial begin
      pins_o = pac_pkg::PINS_RESET;
      mclk_run = 1'b0;
      phase = 2'h0;
   end

   // Burst clock stands still low when stopped; a half period is four system cycles.
   always @(posedge sys_clk_i) begin
      #1;
      if (mclk_run || pins_o.mclk) begin
         phase = phase + 2'h1;
         if (phase == 2'h0) begin
            pins_o.mclk = ~pins_o.mclk;
         end
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   // Data is held well past the strobe's rising edge, since capture happens late.
   task automatic write(input logic [11:0] v, input logic wm, input logic cs);
      pins_o.word_mode = wm;
      pins_o.cs_n = cs;
      pins_o.db = v;
      cyc(1);
      pins_o.wr_n = 1'b0;
      cyc(5);
      pins_o.wr_n = 1'b1;
      cyc(5);
      pins_o.cs_n = 1'b1;
      pins_o.db = ~v;
      cyc(5);
   endtask

   task automatic read(input logic wm, input logic hb, input logic cs, output logic [11:0] v);
      pins_o.word_mode = wm;
      pins_o.db = {3'h7, hb, 8'h5a};
      pins_o.cs_n = cs;
      cyc(1);
      pins_o.rd_n = 1'b0;
      cyc(6);
      v = bus_i;
      pins_o.rd_n = 1'b1;
      cyc(6);
      pins_o.cs_n = 1'b1;
      cyc(1);
   endtask

   task automatic set_mclk(input logic run);
      mclk_run = run;
      cyc(12);
   endtask

   // A running clock is met right after its rise, so no edge falls between trigger and hold.
   task automatic convert(output int gap);
      int  n;
      logic cont;
      n = 0;
      gap = 0;
      cont = mclk_run;
      if (cont) begin
         @(posedge pins_o.mclk);
         cyc(1);
      end
      pins_o.trig_n = 1'b0;
      while (!busy_i && n < 12) begin
         cyc(1);
         n++;
      end
      mclk_run = 1'b1;
      pins_o.trig_n = 1'b1;
      while (hold_i && n < 400) begin
         cyc(1);
         n++;
      end
      while (busy_i && gap < 40) begin
         cyc(1);
         gap++;
      end
      mclk_run = cont;
   endtask

   task automatic pulse();
      pins_o.trig_n = 1'b0;
      cyc(6);
      pins_o.trig_n = 1'b1;
      cyc(8);
   endtask
endmodule

// ### bench/pac_port_bench.sv
// Self-checking bench of the converter port driven by the host model.
`timescale 1ns/1ns
module pac_port_bench;
   localparam int T2 = 2;
   logic               sys_clk;
   logic               rst_n;
   logic [11:0]        code;
   logic [11:0]        db_o;
   logic [11:0]        db_oe;
   logic [11:0]        bus;
   logic [2:0]         chan;
   logic               busy;
   logic               hold;
   logic               powered;
   pac_pkg::pac_pins_t pins;
   int                 num_errors = 0;
   int                 n_tests = 0;

   assign bus = (db_oe & db_o) | (~db_oe & pins.db);

   pac_port #(.T2_CYC(T2)) u_pac_port (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sample_trigger_n_i(pins.trig_n), .cs_n_i(pins.cs_n),
      .rd_n_i(pins.rd_n), .wr_n_i(pins.wr_n), .word_mode_i(pins.word_mode),
      .master_clock_input_i(pins.mclk), .busy_o(busy), .db_i(bus), .db_o(db_o), .db_oe_o(db_oe),
      .conv_code_i(code), .hold_o(hold), .chan_sel_o(chan), .powered_o(powered));

   pac_host_model u_pac_host_model (.sys_clk_i(sys_clk), .busy_i(busy), .hold_i(hold), .bus_i(bus), .pins_o(pins));

   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask

   task automatic close_out();
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic conv(input logic [11:0] c);
      int gap;
      code = c;
      u_pac_host_model.convert(gap);
      chk("busy tail", 12'(T2 + 1), 12'(gap));
   endtask

   task automatic rd_chk(input string what, input logic wm, input logic hb, input logic [11:0] exp);
      logic [11:0] v;
      u_pac_host_model.read(wm, hb, 1'b0, v);
      chk(what, exp, wm ? v : {4'h0, v[7:0]});
   endtask

   task automatic t_reset();
      chk("reset outputs", 12'h001, {6'h00, busy, hold, chan, powered});
      chk("reset bus enable", 12'h000, db_oe);
   endtask

   task automatic t_word();
      logic [11:0] v;
      u_pac_host_model.write(12'h140, 1'b1, 1'b0);
      u_pac_host_model.write(12'h080, 1'b1, 1'b1);
      conv(12'ha5c);
      chk("channel word write", 12'h005, {9'h000, chan});
      u_pac_host_model.read(1'b1, 1'b0, 1'b1, v);
      rd_chk("word result", 1'b1, 1'b0, 12'ha5c);
   endtask

   task automatic t_fifo();
      u_pac_host_model.set_mclk(1'b1);
      conv(12'h001);
      conv(12'h002);
      u_pac_host_model.set_mclk(1'b0);
      rd_chk("first result", 1'b1, 1'b0, 12'h001);
      rd_chk("second result", 1'b1, 1'b0, 12'h002);
      rd_chk("empty read", 1'b1, 1'b0, 12'h000);
   endtask

   // The refused high byte would move the channel to four, so the later conversion exposes it.
   task automatic t_byte();
      u_pac_host_model.write(12'h080, 1'b0, 1'b0);
      u_pac_host_model.write(12'h101, 1'b0, 1'b0);
      u_pac_host_model.write(12'h000, 1'b0, 1'b0);
      u_pac_host_model.write(12'h171, 1'b0, 1'b0);
      conv(12'h3e7);
      chk("channel byte write", 12'h006, {9'h000, chan});
      rd_chk("low byte", 1'b0, 1'b0, 12'h0e7);
      rd_chk("high byte", 1'b0, 1'b1, 12'h063);
   endtask

   task automatic t_power();
      logic [1:0] m;
      for (int i = 0; i < 2; i++) begin
         m = (i == 0) ? pac_pkg::PM_AUTO_DOWN : pac_pkg::PM_AUTO_STBY;
         u_pac_host_model.write({10'h000, m}, 1'b1, 1'b0);
         conv(12'h555);
         u_pac_host_model.cyc(3);
         chk("auto power down", 12'h000, {11'h000, powered});
         u_pac_host_model.pulse();
         chk("trigger wake", 12'h001, {11'h000, powered});
         conv(12'haaa);
         rd_chk("result before sleep", 1'b1, 1'b0, 12'h555);
         rd_chk("result after wake", 1'b1, 1'b0, 12'haaa);
         u_pac_host_model.pulse();
      end
      // Full power-down is left only by writing normal mode, so no trigger is given here.
      u_pac_host_model.write(12'h003, 1'b1, 1'b0);
      chk("full power down", 12'h000, {11'h000, powered});
      u_pac_host_model.write(12'h000, 1'b1, 1'b0);
      chk("normal power", 12'h001, {11'h000, powered});
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      rst_n = 1'b0;
      code = 12'h000;
      repeat (2) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      u_pac_host_model.cyc(4);
      t_reset();
      t_word();
      t_fifo();
      t_byte();
      t_power();
      close_out();
   end

   // The planned sequence needs under fifteen hundred cycles; this limit is twenty times that.
   initial begin
      #300000;
      num_errors++;
      close_out();
   end
endmodule
